// ===== stream_write_pkg.sv
package stream_write_pkg;

  // Opcode and feature bit positions
  localparam logic [7:0] OPCODE_STREAM_WRITE = 8'h3B;
  localparam int         URGENT_BIT          = 7;
  localparam int         CONT_ERR_BIT        = 6;
  localparam int         FLUSH_BIT           = 5;
  localparam int         RESUME_BIT          = 4;
  localparam int         STREAM_IDENTIFIER_MSB       = 2;

  // Status register bit positions
  localparam int         ST_BUSY             = 7;
  localparam int         ST_READY            = 6;
  localparam int         ST_STREAM_ERR       = 5;
  localparam int         ST_DATA_REQ         = 3;
  localparam int         ST_ERR              = 0;

  // Error register bit positions
  localparam int         ER_IDNF             = 4;
  localparam int         ER_ABORT            = 2;
  localparam int         ER_TIMEOUT          = 0;

  // Reset values
  localparam logic [7:0] STATUS_RESET        = 8'h40;
  localparam logic [7:0] ERROR_RESET         = 8'h00;

  // Time unit per multiplier step, one microsecond in cycles at 20 MHz
  localparam int         CLK_MHZ             = 20;
  localparam int         UNIT_US             = 1;
  localparam int         UNIT_CYCLES         = UNIT_US * CLK_MHZ;
  localparam int         NUM_STREAMS         = 8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_XFER  = 3'b001,
    ST_FLUSH = 3'b010,
    ST_DONE  = 3'b011
  } cmd_state_type;

endpackage

// ===== word_buffer_if.sv
`timescale 1ns/1ps
interface word_buffer_if #(parameter int WIDTH = 16);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== word_buffer.sv
`timescale 1ns/1ps
module word_buffer
  import stream_write_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  // Data path
  word_buffer_if.buffer bus
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic [WIDTH-1:0] dout_reg;
  logic             dval_reg;
  wire              push = bus.in_valid && bus.in_ready;
  wire              load = (cnt_reg != '0) && (!dval_reg || bus.out_ready);

  // Registered read port; entries stay in memory until moved to the output
  assign bus.in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign bus.out_valid = dval_reg;
  assign bus.out_data  = dout_reg;

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_reg[wr_reg] <= bus.in_data;
    if (load)
      dout_reg <= mem_reg[rd_reg];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      dval_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (load)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg  <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
      if (load)
        dval_reg <= 1'b1;
      else if (bus.out_ready)
        dval_reg <= 1'b0;
    end
  end
endmodule // word_buffer

// ===== stream_limit_table.sv
`timescale 1ns/1ps
module stream_limit_table
  import stream_write_pkg::*;
#(
  parameter int ENTRIES = NUM_STREAMS,
  parameter int WIDTH   = 16
)
(
  // Clock
  input  wire logic                       clk_in,
  // Write port
  input  wire logic                       wr_en_in,
  input  wire logic [$clog2(ENTRIES)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]           wr_data_in,
  // Read port, one cycle latency
  input  wire logic [$clog2(ENTRIES)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]           rd_data_out
);
  logic [WIDTH-1:0] mem_reg [ENTRIES];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_reg[wr_addr_in] <= wr_data_in;
    rd_data_out <= mem_reg[rd_addr_in];
  end
endmodule // stream_limit_table

// ===== stream_pio_write_command.sv
`timescale 1ns/1ps
module stream_pio_write_command
  import stream_write_pkg::*;
#(
  parameter int         WORDS_PER_SECTOR = 256,
  parameter logic [15:0] TIME_UNIT_US    = 16'h0001,
  parameter logic [31:0] MIN_LIMIT_US    = 32'h0000_0064
)
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Task file writes from host interface
  input  wire logic        cmd_wr_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic [7:0]  stream_option_flags_in,
  input  wire logic [7:0]  completion_limit_multiplier_in,
  input  wire logic [15:0] sector_count_in,
  input  wire logic [47:0] lba_in,
  // Per-stream default limit configuration
  input  wire logic        cfg_wr_in,
  input  wire logic [2:0]  cfg_stream_in,
  input  wire logic [15:0] cfg_default_in,
  // PIO data from host
  input  wire logic        host_valid_in,
  input  wire logic [15:0] host_data_in,
  output logic             host_ready_out,
  // Data toward media
  output logic             media_valid_out,
  output logic [15:0]      media_data_out,
  input  wire logic        media_ready_in,
  input  wire logic        media_err_in,
  input  wire logic        media_idnf_in,
  // Flush handshake
  output logic             flush_req_out,
  input  wire logic        flush_done_in,
  // Results
  output logic [7:0]       command_ending_status_out,
  output logic [7:0]       error_out,
  output logic [2:0]       stream_identifier_out,
  output logic [47:0]      start_lba_out,
  output logic             intrq_out
);
  cmd_state_type    state_reg;
  cmd_state_type    state_next;
  logic [16:0]      sectors_reg;
  logic [8:0]       words_reg;
  logic [31:0]      limit_us_reg;
  logic [4:0]       unit_cnt_reg;
  logic [31:0]      us_cnt_reg;
  logic             limit_on_reg;
  logic             limit_pend_reg;
  logic [7:0]       mult_reg;
  logic [7:0]       flags_reg;
  logic [15:0]      cfg_valid_reg;
  logic [47:0]      err_lba_reg [NUM_STREAMS];
  logic [47:0]      cur_lba_reg;
  logic             had_err_reg;
  logic [7:0]       status_reg;
  logic [7:0]       error_reg;
  logic             intrq_reg;
  logic             flush_reg;
  logic [15:0]      default_rd;
  logic [24:0]      host_left_reg;
  word_buffer_if #(.WIDTH(16)) buf_if ();

  wire start = cmd_wr_in && (cmd_in == OPCODE_STREAM_WRITE) && (state_reg == ST_IDLE);
  wire [2:0]  sid      = stream_option_flags_in[STREAM_IDENTIFIER_MSB:0];
  wire [2:0]  cur_sid  = flags_reg[STREAM_IDENTIFIER_MSB:0];
  wire        cont_err = flags_reg[CONT_ERR_BIT];
  wire [16:0] req_sectors = (sector_count_in == 16'h0000) ? 17'h1_0000 : {1'b0, sector_count_in};
  wire        xfer_word   = buf_if.out_valid && media_ready_in;
  wire        last_word   = xfer_word && (words_reg == 9'(WORDS_PER_SECTOR - 1));
  wire        last_sector = last_word && (sectors_reg == 17'h0_0001);
  wire        timed_out   = limit_on_reg && (us_cnt_reg >= limit_us_reg);
  wire [31:0] direct_us   = 32'(mult_reg) * 32'(TIME_UNIT_US);
  wire [31:0] default_us  = 32'(default_rd) * 32'(TIME_UNIT_US);
  wire [31:0] chosen_us   = (mult_reg != 8'h00) ? direct_us : default_us;
  wire        chosen_on   = (mult_reg != 8'h00) ||
                            (cfg_valid_reg[cur_sid] && default_rd != 16'h0000);
  wire [31:0] clamped_us  = (chosen_us < MIN_LIMIT_US) ? MIN_LIMIT_US : chosen_us;

  wire        host_push   = host_valid_in && host_ready_out;
  // Ready drops after each word taken, so a registered ready never overfills
  wire        host_ready_next = (state_next == ST_XFER) && buf_if.in_ready && !host_push &&
                                (host_left_reg != 25'h000_0000);
  wire [47:0] first_lba   = stream_option_flags_in[RESUME_BIT] ? err_lba_reg[sid] : lba_in;
  assign buf_if.in_valid  = host_push;
  assign buf_if.in_data   = host_data_in;
  assign buf_if.out_ready = media_ready_in;

  word_buffer #(.WIDTH(16), .DEPTH(2)) u_buf (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .bus      (buf_if.buffer)
  );

  stream_limit_table #(.ENTRIES(NUM_STREAMS), .WIDTH(16)) u_tbl (
    .clk_in      (clk_in),
    .wr_en_in    (cfg_wr_in),
    .wr_addr_in  (cfg_stream_in),
    .wr_data_in  (cfg_default_in),
    .rd_addr_in  (sid),
    .rd_data_out (default_rd)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start)
          state_next = ST_XFER;
      ST_XFER:
        if (timed_out)
          state_next = ST_DONE;
        else if (last_sector)
          state_next = flags_reg[FLUSH_BIT] ? ST_FLUSH : ST_DONE;
      ST_FLUSH:
        if (flush_done_in || timed_out)
          state_next = ST_DONE;
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Transfer counters and stream position
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sectors_reg <= '0;
      words_reg   <= '0;
      flags_reg   <= '0;
      mult_reg    <= '0;
      cur_lba_reg <= '0;
    end
    else if (start)
    begin
      sectors_reg <= req_sectors;
      words_reg   <= '0;
      flags_reg   <= stream_option_flags_in;
      mult_reg    <= completion_limit_multiplier_in;
      cur_lba_reg <= first_lba;
    end
    else if (xfer_word)
    begin
      words_reg <= last_word ? '0 : words_reg + 9'h001;
      if (last_word)
      begin
        sectors_reg <= sectors_reg - 17'h0_0001;
        cur_lba_reg <= cur_lba_reg + 48'h0000_0000_0001;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cfg_valid_reg <= '0;
    else if (cfg_wr_in)
      cfg_valid_reg[cfg_stream_in] <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (state_reg == ST_XFER && media_err_in)
      err_lba_reg[cur_sid] <= cur_lba_reg;
  end

  // timing from opcode write to interrupt
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      limit_on_reg   <= 1'b0;
      limit_pend_reg <= 1'b0;
      limit_us_reg   <= '0;
      unit_cnt_reg   <= '0;
      us_cnt_reg     <= '0;
    end
    else if (start)
    begin
      limit_on_reg   <= 1'b0;
      limit_pend_reg <= 1'b1;
      unit_cnt_reg   <= '0;
      us_cnt_reg     <= '0;
    end
    else
    begin
      // Table read takes one cycle, so the limit settles after the start
      if (limit_pend_reg)
      begin
        limit_pend_reg <= 1'b0;
        limit_on_reg   <= chosen_on;
        limit_us_reg   <= clamped_us;
      end
      if (unit_cnt_reg == 5'(UNIT_CYCLES - 1))
      begin
        unit_cnt_reg <= '0;
        us_cnt_reg   <= us_cnt_reg + 32'h0000_0001;
      end
      else
        unit_cnt_reg <= unit_cnt_reg + 5'h01;
    end
  end

  // Ending status, error log and interrupt
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      status_reg  <= STATUS_RESET;
      error_reg   <= ERROR_RESET;
      had_err_reg <= 1'b0;
      intrq_reg   <= 1'b0;
      flush_reg   <= 1'b0;
    end
    else
    begin
      intrq_reg <= 1'b0;
      flush_reg <= (state_next == ST_FLUSH);
      if (start)
      begin
        status_reg  <= 8'h00;
        status_reg[ST_BUSY] <= 1'b1;
        error_reg   <= ERROR_RESET;
        had_err_reg <= 1'b0;
      end
      else if (state_reg == ST_XFER || state_reg == ST_FLUSH)
      begin
        status_reg[ST_BUSY]     <= 1'b0;
        status_reg[ST_DATA_REQ] <= (state_reg == ST_XFER);
        if (media_err_in)
        begin
          had_err_reg <= 1'b1;
          error_reg[ER_IDNF]  <= error_reg[ER_IDNF] | media_idnf_in;
          error_reg[ER_ABORT] <= error_reg[ER_ABORT] | !media_idnf_in;
        end
        if (timed_out)
          error_reg[ER_TIMEOUT] <= 1'b1;
      end
      else if (state_reg == ST_DONE)
      begin
        status_reg[ST_BUSY]     <= 1'b0;
        status_reg[ST_READY]    <= 1'b1;
        status_reg[ST_DATA_REQ] <= 1'b0;
        // stream error, no ERR with continue
        status_reg[ST_STREAM_ERR] <= had_err_reg || error_reg[ER_TIMEOUT];
        status_reg[ST_ERR] <= !cont_err && (had_err_reg || error_reg[ER_TIMEOUT]);
        intrq_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      host_left_reg  <= '0;
      host_ready_out <= 1'b0;
    end
    else
    begin
      if (start)
        host_left_reg <= 25'(req_sectors) * 25'(WORDS_PER_SECTOR);
      else if (host_push)
        host_left_reg <= host_left_reg - 25'h000_0001;
      host_ready_out <= host_ready_next;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stream_identifier_out <= '0;
      start_lba_out         <= '0;
    end
    else if (start)
    begin
      stream_identifier_out <= sid;
      start_lba_out         <= first_lba;
    end
  end

  // Buffer output stage is the media register, so stalls hold the word
  assign media_valid_out           = buf_if.out_valid;
  assign media_data_out            = buf_if.out_data;
  assign command_ending_status_out = status_reg;
  assign error_out                 = error_reg;
  assign intrq_out                 = intrq_reg;
  assign flush_req_out             = flush_reg;
endmodule // stream_pio_write_command

// ===== stream_write_checker.sv
`timescale 1ns/1ps
module stream_write_checker
  import stream_write_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        cmd_wr_in,
  input wire logic [7:0]  cmd_in,
  input wire logic [7:0]  stream_option_flags_in,
  input wire logic        media_ready_in,
  input wire logic        flush_done_in,
  input wire logic        media_valid_out,
  input wire logic [15:0] media_data_out,
  input wire logic        flush_req_out,
  input wire logic [7:0]  command_ending_status_out,
  input wire logic [7:0]  error_out,
  input wire logic [2:0]  stream_identifier_out,
  input wire logic        intrq_out
);
  logic cont_reg;
  logic flush_reg;
  logic flushed_reg;
  wire  idle_w   = !command_ending_status_out[ST_BUSY];
  wire  accept_w = cmd_wr_in && cmd_in == OPCODE_STREAM_WRITE && idle_w;
  wire  other_w  = cmd_wr_in && cmd_in != OPCODE_STREAM_WRITE && idle_w;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cont_reg    <= 1'b0;
      flush_reg   <= 1'b0;
      flushed_reg <= 1'b0;
    end
    else if (accept_w)
    begin
      cont_reg    <= stream_option_flags_in[CONT_ERR_BIT];
      flush_reg   <= stream_option_flags_in[FLUSH_BIT];
      flushed_reg <= 1'b0;
    end
    else if (flush_req_out && flush_done_in)
      flushed_reg <= 1'b1;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence accept_s;
    accept_w;
  endsequence
  sequence done_s;
    intrq_out ##1 !intrq_out;
  endsequence

  reset_value_a: assert property (disable iff (1'b0) !rst_n_in |=>
    command_ending_status_out == STATUS_RESET && error_out == ERROR_RESET)
    else $error("status or error wrong after reset");
  busy_start_a: assert property (accept_s |=> !idle_w)
    else $error("accepted command did not raise busy");
  foreign_op_a: assert property (other_w |=> idle_w)
    else $error("other opcode started a command");
  stream_pick_a: assert property (accept_s |=>
    stream_identifier_out == $past(stream_option_flags_in[STREAM_IDENTIFIER_MSB:0]))
    else $error("stream identifier not taken from flags");
  intrq_pulse_a: assert property (intrq_out |-> done_s and idle_w)
    else $error("interrupt not a single pulse with busy clear");
  cont_noerr_a: assert property (intrq_out && cont_reg |->
    !command_ending_status_out[ST_ERR])
    else $error("error bit set in continue mode");
  timeout_se_a: assert property (intrq_out && cont_reg && error_out[ER_TIMEOUT] |->
    command_ending_status_out[ST_STREAM_ERR])
    else $error("timeout without stream error");
  flush_first_a: assert property (intrq_out && flush_reg |-> flushed_reg)
    else $error("completion before flush finished");
  media_hold_a: assert property (media_valid_out && !media_ready_in |=>
    media_valid_out && $stable(media_data_out))
    else $error("media word dropped or changed while stalled");
endmodule // stream_write_checker

bind stream_pio_write_command stream_write_checker chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in), .cmd_in(cmd_in),
  .stream_option_flags_in(stream_option_flags_in), .media_ready_in(media_ready_in),
  .flush_done_in(flush_done_in), .media_valid_out(media_valid_out),
  .media_data_out(media_data_out), .flush_req_out(flush_req_out),
  .command_ending_status_out(command_ending_status_out), .error_out(error_out),
  .stream_identifier_out(stream_identifier_out), .intrq_out(intrq_out));

// ===== host_model.sv
`timescale 1ns/1ps
module host_model
(
  input  wire logic  clk_in,
  input  wire logic  run_in,
  input  wire logic  stall_in,
  input  wire logic  ready_in,
  output logic       valid_out,
  output logic [15:0] data_out
);
  logic took;
  initial
  begin
    valid_out = 1'b0;
    data_out  = 16'h0000;
  end
  // Word held until taken; released data inverts
  always @(posedge clk_in)
  begin
    took = valid_out && ready_in;
    #2;
    if (took || !valid_out)
    begin
      valid_out = run_in && !stall_in;
      data_out  = valid_out ? data_out + 16'h0001 : ~data_out;
    end
  end
endmodule // host_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import stream_write_pkg::*;
  localparam int          WPS    = 4;
  localparam int          TU_US  = 1;
  localparam logic [31:0] MIN_US = 32'h0000_0005;
  logic clk_in, rst_n_in, cmd_wr_in, cfg_wr_in, host_valid_in, host_ready_out, host_run;
  logic host_stall, media_ready_in, media_err_in, media_idnf_in, flush_done_in;
  logic media_valid_out, flush_req_out, intrq_out, flush_seen;
  logic [7:0]  cmd_in, flags, mult, command_ending_status_out, error_out;
  logic [15:0] sector_count_in, host_data_in, media_data_out, cfg_default_in, lfsr, m;
  logic [2:0]  cfg_stream_in, stream_identifier_out;
  logic [47:0] lba_in, start_lba_out, err_lba;
  logic [15:0] sent_q [$];
  int          failures, n_checks, cycles, n_words, cyc;

  stream_pio_write_command #(.WORDS_PER_SECTOR(WPS), .TIME_UNIT_US(16'h0001),
    .MIN_LIMIT_US(MIN_US)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in), .cmd_in(cmd_in),
    .stream_option_flags_in(flags), .completion_limit_multiplier_in(mult),
    .sector_count_in(sector_count_in), .lba_in(lba_in), .cfg_wr_in(cfg_wr_in),
    .cfg_stream_in(cfg_stream_in), .cfg_default_in(cfg_default_in),
    .host_valid_in(host_valid_in), .host_data_in(host_data_in),
    .host_ready_out(host_ready_out), .media_valid_out(media_valid_out),
    .media_data_out(media_data_out), .media_ready_in(media_ready_in),
    .media_err_in(media_err_in), .media_idnf_in(media_idnf_in),
    .flush_req_out(flush_req_out), .flush_done_in(flush_done_in),
    .command_ending_status_out(command_ending_status_out), .error_out(error_out),
    .stream_identifier_out(stream_identifier_out), .start_lba_out(start_lba_out),
    .intrq_out(intrq_out));
  host_model host_u (.clk_in(clk_in), .run_in(host_run), .stall_in(host_stall),
    .ready_in(host_ready_out), .valid_out(host_valid_in), .data_out(host_data_in));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic int exp_words(input logic [15:0] c);
    return (c == 16'h0000 ? 65536 : int'(c)) * WPS;
  endfunction
  function automatic int exp_limit(input logic [7:0] mu);
    int us;
    us = int'(mu) * TU_US;
    if (us < int'(MIN_US))
      us = int'(MIN_US);
    return us * UNIT_CYCLES;
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] fl, input logic [7:0] mu,
                     input logic [15:0] cnt, input int stall_n, input int limit);
    flags = fl;
    mult = mu;
    sector_count_in = cnt;
    lba_in = {rnd(), rnd(), rnd()};
    n_words = 0;
    flush_seen = 1'b0;
    @(posedge clk_in); #2;
    cmd_in = op;
    cmd_wr_in = 1'b1;
    @(posedge clk_in); #2;
    cmd_wr_in = 1'b0;
    host_run = 1'b1;
    cyc = 0;
    while (intrq_out !== 1'b1 && cyc < limit)
    begin
      host_stall = cyc < stall_n;
      @(posedge clk_in); #2;
      cyc++;
    end
    host_run = 1'b0;
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Media side stalls at random, answers flush late
  always @(posedge clk_in)
  begin
    cycles++;
    if (media_valid_out && media_ready_in)
    begin
      n_words++;
      if (sent_q.size() == 0)
        chk(sent_q.size(), 1);
      else
        chk(media_data_out, sent_q.pop_front());
    end
    if (host_valid_in && host_ready_out)
      sent_q.push_back(host_data_in);
    if (flush_req_out && flush_done_in)
      flush_seen = 1'b1;
    if (cycles == 40000)
    begin
      failures++;
      $display("mismatch at %0t: run timed out", $time);
      final_report();
    end
    #2;
    m = rnd();
    media_ready_in = m[0] | m[1];
    media_idnf_in = media_err_in & m[2];
    flush_done_in = flush_req_out & m[3];
  end

  initial
  begin
    logic [15:0] r;
    logic [15:0] cnt;
    lfsr = 16'h72b4;
    {rst_n_in, cmd_wr_in, cfg_wr_in, host_run, host_stall, media_err_in} = '0;
    {cmd_in, flags, mult, sector_count_in, cfg_default_in, cfg_stream_in, lba_in} = '0;
    {media_ready_in, media_idnf_in, flush_done_in} = '0;
    repeat (8) @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    @(posedge clk_in); #2;
    chk(command_ending_status_out, STATUS_RESET);
    chk(error_out, ERROR_RESET);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      cnt = {14'h0000, r[9:8]} + 16'h0001;
      run(OPCODE_STREAM_WRITE, {r[7], 4'h0, r[2:0]}, 8'hff, cnt, r[12:11], 3000);
      chk(n_words, exp_words(cnt));
      chk(cyc < exp_limit(8'hff), 1'b1);
      chk(stream_identifier_out, r[2:0]);
      chk(start_lba_out, lba_in);
      chk(command_ending_status_out & 8'ha1, 8'h00);
    end
    $display("test plain writes done");
    media_err_in = 1'b1;
    run(OPCODE_STREAM_WRITE, 8'h41, 8'hff, 16'h0003, 0, 3000);
    media_err_in = 1'b0;
    chk(n_words, exp_words(16'h0003));
    chk(command_ending_status_out & 8'ha1, 8'h20);
    chk(error_out[ER_IDNF] | error_out[ER_ABORT], 1'b1);
    // Errors ran through every sector, so the last one is the final sector
    err_lba = lba_in + 48'h0000_0000_0002;
    run(OPCODE_STREAM_WRITE, 8'h51, 8'hff, 16'h0001, 0, 3000);
    chk(start_lba_out, err_lba);
    chk(n_words, exp_words(16'h0001));
    $display("test continue on error done");
    run(OPCODE_STREAM_WRITE, 8'h42, 8'h01, 16'h0002, 5000, 3000);
    chk(cyc >= exp_limit(8'h01) - 2 && cyc <= exp_limit(8'h01) + 4, 1'b1);
    chk(error_out[ER_TIMEOUT], 1'b1);
    chk(command_ending_status_out & 8'ha1, 8'h20);
    @(posedge clk_in); #2;
    cfg_wr_in = 1'b1;
    cfg_stream_in = 3'h3;
    cfg_default_in = 16'h000a;
    @(posedge clk_in); #2;
    cfg_wr_in = 1'b0;
    run(OPCODE_STREAM_WRITE, 8'h43, 8'h00, 16'h0001, 5000, 3000);
    chk(cyc >= exp_limit(8'h0a) - 2 && cyc <= exp_limit(8'h0a) + 4, 1'b1);
    run(OPCODE_STREAM_WRITE, 8'h45, 8'h00, 16'h0001, 600, 3000);
    chk(cyc >= 600, 1'b1);
    chk(error_out[ER_TIMEOUT], 1'b0);
    $display("test time limits done");
    run(OPCODE_STREAM_WRITE, 8'h26, 8'hff, 16'h0002, 0, 3000);
    chk(flush_seen, 1'b1);
    chk(n_words, exp_words(16'h0002));
    run(8'h3a, 8'h00, 8'hff, 16'h0001, 0, 60);
    chk(cyc, 60);
    $display("test flush and opcode done");
    final_report();
  end
endmodule // tb_top
